// ### shared/dmx_pkg.sv
// Opcodes, bit area base, timing and reset values for the data-move executor
package dmx_pkg;
    typedef enum logic [3:0] {
        OP_NONE,
        OP_BIT2C,
        OP_DATA_POINTER_IMM,
        OP_REG_IMM,
        OP_A2REG,
        OP_DIR2REG,
        OP_C2BIT,
        OP_IMM2DIR,
        OP_IND2DIR,
        OP_A2DIR,
        OP_REG2DIR,
        OP_DIR2DIR,
        OP_CODE_DATA_POINTER,
        OP_CODE_PC
    } op_e;

    // Full opcodes
    localparam logic [7:0] OPC_BIT2C     = 8'ha2;
    localparam logic [7:0] OPC_DATA_POINTER_IMM  = 8'h90;
    localparam logic [7:0] OPC_C2BIT     = 8'h92;
    localparam logic [7:0] OPC_IMM2DIR   = 8'h75;
    localparam logic [7:0] OPC_A2DIR     = 8'hf5;
    localparam logic [7:0] OPC_DIR2DIR   = 8'h85;
    localparam logic [7:0] OPC_CODE_DATA_POINTER = 8'h93;
    localparam logic [7:0] OPC_CODE_PC   = 8'h83;
    // Upper five bits, register in the low three
    localparam logic [4:0] OPC5_REG_IMM  = 5'h0f;
    localparam logic [4:0] OPC5_A2REG    = 5'h1f;
    localparam logic [4:0] OPC5_DIR2REG  = 5'h15;
    localparam logic [4:0] OPC5_REG2DIR  = 5'h11;
    // Upper seven bits, pointer register in bit 0
    localparam logic [6:0] OPC7_IND2DIR  = 7'h43;

    // Bit-addressable area for bit addresses below 128
    localparam logic [7:0] BIT_AREA_BASE = 8'h20;
    // Clocks per machine cycle
    localparam logic [2:0] CLKS_PER_CYC  = 3'h2;

    // Reset values
    localparam logic [7:0]  ACC_RST  = 8'h00;
    localparam logic [15:0] DATA_POINTER_RST = 16'h0000;
    localparam logic [15:0] PC_RST   = 16'h0000;
    localparam logic [7:0]  WREG_RST = 8'h00;
endpackage

// ### shared/dmx_dec_if.sv
// Opcode in, decoded operation, length and cycle count out
`timescale 1ns/1ps
interface dmx_dec_if;
    logic [7:0]     opcode;
    dmx_pkg::op_e   op;
    logic [1:0]     len;
    logic [1:0]     cyc;

    modport dec (input opcode, output op, len, cyc);
    modport user (output opcode, input op, len, cyc);
endinterface

// ### rtl/dmx_decode.sv
// Opcode decoder for the data-move group
`timescale 1ns/1ps
module dmx_decode (
    // Decode port
    dmx_dec_if.dec dec
);
    wire [7:0] opc = dec.opcode;
    wire h_bit2c = opc == dmx_pkg::OPC_BIT2C;
    wire h_data_pointer  = opc == dmx_pkg::OPC_DATA_POINTER_IMM;
    wire h_rimm  = opc[7:3] == dmx_pkg::OPC5_REG_IMM;
    wire h_a2r   = opc[7:3] == dmx_pkg::OPC5_A2REG;
    wire h_d2r   = opc[7:3] == dmx_pkg::OPC5_DIR2REG;
    wire h_c2bit = opc == dmx_pkg::OPC_C2BIT;
    wire h_i2d   = opc == dmx_pkg::OPC_IMM2DIR;
    wire h_ind   = opc[7:1] == dmx_pkg::OPC7_IND2DIR;
    wire h_a2d   = opc == dmx_pkg::OPC_A2DIR;
    wire h_r2d   = opc[7:3] == dmx_pkg::OPC5_REG2DIR;
    wire h_d2d   = opc == dmx_pkg::OPC_DIR2DIR;
    wire h_cdp   = opc == dmx_pkg::OPC_CODE_DATA_POINTER;
    wire h_cpc   = opc == dmx_pkg::OPC_CODE_PC;

    assign dec.op = h_bit2c ? dmx_pkg::OP_BIT2C :
                    h_data_pointer  ? dmx_pkg::OP_DATA_POINTER_IMM :
                    h_rimm  ? dmx_pkg::OP_REG_IMM :
                    h_a2r   ? dmx_pkg::OP_A2REG :
                    h_d2r   ? dmx_pkg::OP_DIR2REG :
                    h_c2bit ? dmx_pkg::OP_C2BIT :
                    h_i2d   ? dmx_pkg::OP_IMM2DIR :
                    h_ind   ? dmx_pkg::OP_IND2DIR :
                    h_a2d   ? dmx_pkg::OP_A2DIR :
                    h_r2d   ? dmx_pkg::OP_REG2DIR :
                    h_d2d   ? dmx_pkg::OP_DIR2DIR :
                    h_cdp   ? dmx_pkg::OP_CODE_DATA_POINTER :
                    h_cpc   ? dmx_pkg::OP_CODE_PC : dmx_pkg::OP_NONE;

    // Byte length and machine cycles
    wire three = h_data_pointer | h_i2d | h_d2d;
    wire two   = h_bit2c | h_rimm | h_d2r | h_c2bit | h_ind | h_a2d | h_r2d;
    assign dec.len = three ? 2'd3 : two ? 2'd2 : 2'd1;
    wire slow = h_data_pointer | h_d2r | h_c2bit | h_i2d | h_ind | h_r2d | h_d2d | h_cdp | h_cpc;
    assign dec.cyc = slow ? 2'd2 : 2'd1;
endmodule // dmx_decode

// ### rtl/dmx_bit_unit.sv
// Bit address to byte address, bit select and carry merge
`timescale 1ns/1ps
module dmx_bit_unit (
    // Operands
    input  wire logic [7:0] i_bit_addr,
    input  wire logic [7:0] i_rdata,
    input  wire logic       i_carry,
    // Results
    output logic [7:0]      o_byte_addr,
    output logic            o_bit,
    output logic [7:0]      o_merged
);
    wire [7:0] low_byte = dmx_pkg::BIT_AREA_BASE | {4'h0, i_bit_addr[6:3]};
    assign o_byte_addr = i_bit_addr[7] ? {i_bit_addr[7:3], 3'b000} : low_byte;
    assign o_bit = i_rdata[i_bit_addr[2:0]];

    // Replace only the addressed bit
    for (genvar g = 0; g < 8; g++)
    begin : g_mrg
        assign o_merged[g] = (i_bit_addr[2:0] == 3'(g)) ? i_carry : i_rdata[g];
    end
endmodule // dmx_bit_unit

// ### rtl/data_move_instruction_exec.sv
// Data-move instruction executor: sequencing, state and memory ports
`timescale 1ns/1ps
module data_move_instruction_exec (
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_nrst,
    // Instruction from fetch
    input  wire logic        i_instr_valid,
    input  wire logic [7:0]  i_opcode,
    input  wire logic [7:0]  i_arg1,
    input  wire logic [7:0]  i_arg2,
    output logic             o_instr_ready,
    output logic             o_instr_done,
    output logic             o_unknown,
    // Internal data memory
    output logic             o_dmem_re,
    output logic [7:0]       o_dmem_raddr,
    input  wire logic [7:0]  i_dmem_rdata,
    output logic             o_dmem_we,
    output logic [7:0]       o_dmem_waddr,
    output logic [7:0]       o_dmem_wdata,
    // Code memory
    output logic             o_cmem_re,
    output logic [7:0]       o_port2,
    output logic [7:0]       o_port0,
    input  wire logic [7:0]  i_code_rdata,
    // Processor state
    output logic [7:0]       o_acc,
    output logic             o_carry,
    output logic             o_parity,
    output logic [15:0]      o_data_pointer,
    output logic [15:0]      o_pc,
    output logic [63:0]      o_working_register
);
    logic          busy_q;
    logic [2:0]    step_q;
    logic [2:0]    last_q;
    dmx_pkg::op_e  op_q;
    logic [7:0]    opc_q;
    logic [7:0]    arg1_q;
    logic [7:0]    arg2_q;
    logic [1:0]    len_q;
    logic [7:0]    acc_q;
    logic          carry_q;
    logic          parity_q;
    logic [15:0]   data_pointer_q;
    logic [15:0]   pc_q;
    logic [7:0]    wr_q [8];

    dmx_dec_if dec_bus ();
    assign dec_bus.opcode = i_opcode;
    dmx_decode u_dec (
        .dec (dec_bus)
    );

    // Step decoding
    wire take  = i_instr_valid & o_instr_ready;
    wire first = busy_q & (step_q == 3'd0);
    wire work  = busy_q & (step_q == 3'd1);
    wire fin   = busy_q & (step_q == last_q);
    wire [2:0] sel = opc_q[2:0];

    wire is_b2c  = op_q == dmx_pkg::OP_BIT2C;
    wire is_data_pointer = op_q == dmx_pkg::OP_DATA_POINTER_IMM;
    wire is_rimm = op_q == dmx_pkg::OP_REG_IMM;
    wire is_a2r  = op_q == dmx_pkg::OP_A2REG;
    wire is_d2r  = op_q == dmx_pkg::OP_DIR2REG;
    wire is_c2b  = op_q == dmx_pkg::OP_C2BIT;
    wire is_i2d  = op_q == dmx_pkg::OP_IMM2DIR;
    wire is_ind  = op_q == dmx_pkg::OP_IND2DIR;
    wire is_a2d  = op_q == dmx_pkg::OP_A2DIR;
    wire is_r2d  = op_q == dmx_pkg::OP_REG2DIR;
    wire is_d2d  = op_q == dmx_pkg::OP_DIR2DIR;
    wire is_cdp  = op_q == dmx_pkg::OP_CODE_DATA_POINTER;
    wire is_cpc  = op_q == dmx_pkg::OP_CODE_PC;
    wire is_bit  = is_b2c | is_c2b;

    // Bit address handling
    wire [7:0] bit_byte;
    wire       bit_val;
    wire [7:0] bit_merged;
    dmx_bit_unit u_bit (
        .i_bit_addr  (arg1_q),
        .i_rdata     (i_dmem_rdata),
        .i_carry     (carry_q),
        .o_byte_addr (bit_byte),
        .o_bit       (bit_val),
        .o_merged    (bit_merged)
    );

    // Data memory read in step 0, data back in step 1
    wire need_rd = is_bit | is_ind | is_d2r | is_d2d;
    wire [7:0] ind_ptr = wr_q[{2'b00, opc_q[0]}];
    assign o_dmem_re    = first & need_rd;
    assign o_dmem_raddr = is_bit ? bit_byte : is_ind ? ind_ptr : arg1_q;

    // Data memory write in step 1
    wire need_wr = is_c2b | is_i2d | is_ind | is_a2d | is_r2d | is_d2d;
    assign o_dmem_we    = work & need_wr;
    assign o_dmem_waddr = is_c2b ? bit_byte : is_d2d ? arg2_q : arg1_q;
    assign o_dmem_wdata = is_c2b ? bit_merged :
                          is_i2d ? arg2_q :
                          is_a2d ? acc_q :
                          is_r2d ? wr_q[sel] :
                          i_dmem_rdata;

    // Code table address
    wire [15:0] pc_inc    = pc_q + 16'h0001;
    wire [15:0] code_base = is_cpc ? pc_inc : data_pointer_q;
    wire [15:0] code_addr = code_base + {8'h00, acc_q};
    assign o_cmem_re = first & (is_cdp | is_cpc);
    assign o_port2   = code_addr[15:8];
    assign o_port0   = code_addr[7:0];

    // Handshake
    assign o_instr_ready = ~busy_q;
    assign o_instr_done  = fin;
    assign o_unknown     = fin & (op_q == dmx_pkg::OP_NONE);

    // Sequencer
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            busy_q <= 1'b0;
            step_q <= 3'd0;
            last_q <= 3'd0;
            op_q   <= dmx_pkg::OP_NONE;
            opc_q  <= 8'h00;
            arg1_q <= 8'h00;
            arg2_q <= 8'h00;
            len_q  <= 2'd0;
        end
        else if (take)
        begin
            busy_q <= 1'b1;
            step_q <= 3'd0;
            last_q <= 3'(dec_bus.cyc * dmx_pkg::CLKS_PER_CYC - 3'd1);
            op_q   <= dec_bus.op;
            opc_q  <= i_opcode;
            arg1_q <= i_arg1;
            arg2_q <= i_arg2;
            len_q  <= dec_bus.len;
        end
        else if (busy_q)
        begin
            busy_q <= ~fin;
            step_q <= step_q + 3'd1;
        end
    end

    // Accumulator, carry, data pointer, program counter
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            acc_q    <= dmx_pkg::ACC_RST;
            parity_q <= 1'b0;
            carry_q  <= 1'b0;
            data_pointer_q   <= dmx_pkg::DATA_POINTER_RST;
            pc_q     <= dmx_pkg::PC_RST;
        end
        else
        begin
            if (work & (is_cdp | is_cpc))
            begin
                acc_q    <= i_code_rdata;
                parity_q <= ^i_code_rdata;
            end
            if (work & is_b2c)
                carry_q <= bit_val;
            if (work & is_data_pointer)
                data_pointer_q <= {arg1_q, arg2_q};
            if (first & is_cpc)
                pc_q <= pc_inc;
            else if (fin & ~is_cpc)
                pc_q <= pc_q + {14'h0000, len_q};
        end
    end

    // Working registers
    wire       wreg_wr = work & (is_rimm | is_a2r | is_d2r);
    wire [7:0] wreg_d  = is_rimm ? arg1_q : is_a2r ? acc_q : i_dmem_rdata;
    for (genvar g = 0; g < 8; g++)
    begin : g_wr
        always_ff @(posedge i_clk or negedge i_nrst)
        begin
            if (!i_nrst)
                wr_q[g] <= dmx_pkg::WREG_RST;
            else if (wreg_wr && sel == 3'(g))
                wr_q[g] <= wreg_d;
        end
        assign o_working_register[g*8 +: 8] = wr_q[g];
    end

    assign o_acc          = acc_q;
    assign o_carry        = carry_q;
    assign o_parity       = parity_q;
    assign o_data_pointer = data_pointer_q;
    assign o_pc           = pc_q;

    // Checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);

    property p_carry_src;
        $changed(carry_q) |-> $past(work && is_b2c);
    endproperty
    a_carry_src: assert property (p_carry_src) else $error("carry moved");

    property p_b2c_time;
        take && dec_bus.op == dmx_pkg::OP_BIT2C |-> ##2 o_instr_done;
    endproperty
    a_b2c_time: assert property (p_b2c_time) else $error("bit load time");

    property p_data_pointer_load;
        take && dec_bus.op == dmx_pkg::OP_DATA_POINTER_IMM |-> ##4 o_instr_done
            && data_pointer_q == {$past(i_arg1, 4), $past(i_arg2, 4)};
    endproperty
    a_data_pointer_load: assert property (p_data_pointer_load) else $error("pointer load");

    property p_rimm;
        work && is_rimm |=> wr_q[$past(sel)] == $past(arg1_q);
    endproperty
    a_rimm: assert property (p_rimm) else $error("reg immediate");

    property p_a2dir;
        take && dec_bus.op == dmx_pkg::OP_A2DIR |-> ##2 o_dmem_we
            && o_dmem_waddr == $past(i_arg1, 2) && o_dmem_wdata == acc_q;
    endproperty
    a_a2dir: assert property (p_a2dir) else $error("acc to direct");

    property p_d2d;
        o_dmem_we && is_d2d |-> $past(o_dmem_raddr) == arg1_q
            && o_dmem_waddr == arg2_q;
    endproperty
    a_d2d: assert property (p_d2d) else $error("direct copy");

    property p_cdp;
        o_cmem_re && is_cdp |-> {o_port2, o_port0} == data_pointer_q + {8'h00, acc_q}
            ##1 $stable(data_pointer_q) ##1 $stable(data_pointer_q);
    endproperty
    a_cdp: assert property (p_cdp) else $error("pointer lookup");

    property p_cpc;
        take && dec_bus.op == dmx_pkg::OP_CODE_PC |=> ##1 pc_q == $past(pc_q) + 16'h0001
            ##3 $stable(pc_q);
    endproperty
    a_cpc: assert property (p_cpc) else $error("pc lookup");

    property p_pc_adv;
        o_instr_done && !is_cpc |=> pc_q == $past(pc_q) + {14'h0000, $past(len_q)};
    endproperty
    a_pc_adv: assert property (p_pc_adv) else $error("pc advance");

    property p_a2reg;
        work && is_a2r |=> wr_q[$past(sel)] == $past(acc_q);
    endproperty
    a_a2reg: assert property (p_a2reg) else $error("acc to reg");

    property p_d2r;
        take && dec_bus.op == dmx_pkg::OP_DIR2REG |-> ##1 o_dmem_re
            && o_dmem_raddr == $past(i_arg1) ##3 o_instr_done;
    endproperty
    a_d2r: assert property (p_d2r) else $error("direct to reg");

    property p_c2bit;
        o_dmem_we && is_c2b |-> o_dmem_waddr == $past(o_dmem_raddr)
            && o_dmem_wdata[arg1_q[2:0]] == carry_q;
    endproperty
    a_c2bit: assert property (p_c2bit) else $error("carry to bit");

    property p_i2d;
        take && dec_bus.op == dmx_pkg::OP_IMM2DIR |-> ##2 o_dmem_we
            && o_dmem_waddr == $past(i_arg1, 2) && o_dmem_wdata == $past(i_arg2, 2);
    endproperty
    a_i2d: assert property (p_i2d) else $error("imm to direct");

    property p_ind;
        o_dmem_re && is_ind |-> o_dmem_raddr == (opc_q[0] ? wr_q[1] : wr_q[0])
            ##1 o_dmem_we && o_dmem_waddr == arg1_q && o_dmem_wdata == i_dmem_rdata;
    endproperty
    a_ind: assert property (p_ind) else $error("indirect to direct");

    property p_r2d;
        take && dec_bus.op == dmx_pkg::OP_REG2DIR |-> ##2 o_dmem_we
            && o_dmem_waddr == $past(i_arg1, 2) && o_dmem_wdata == wr_q[sel];
    endproperty
    a_r2d: assert property (p_r2d) else $error("reg to direct");

    c_b2c: cover property (o_instr_done && is_b2c);
    c_d2d: cover property (o_dmem_we && is_d2d);
    c_cpc: cover property (o_instr_done && is_cpc);
    c_b2b: cover property (o_instr_done ##1 take);
endmodule // data_move_instruction_exec

// ### tb/dmx_mem_model.sv
// Internal data memory and code memory model for the executor bench
`timescale 1ns/1ps
module dmx_mem_model (
    // Clock
    input  wire logic       i_clk,
    // Data memory
    input  wire logic       i_dmem_re,
    input  wire logic [7:0] i_dmem_raddr,
    output logic [7:0]      o_dmem_rdata,
    input  wire logic       i_dmem_we,
    input  wire logic [7:0] i_dmem_waddr,
    input  wire logic [7:0] i_dmem_wdata,
    // Code memory
    input  wire logic       i_cmem_re,
    input  wire logic [7:0] i_port2,
    input  wire logic [7:0] i_port0,
    output logic [7:0]      o_code_rdata
);
    logic [7:0] cells [256];

    initial
    begin
        for (int i = 0; i < 256; i++)
            cells[i] = 8'(i) ^ 8'h5a;
        o_dmem_rdata = 8'h00;
        o_code_rdata = 8'h00;
    end

    // Read data arrives the cycle after its strobe and then holds
    always @(posedge i_clk)
    begin
        if (i_dmem_re === 1'b1)
            o_dmem_rdata <= cells[i_dmem_raddr];
        if (i_dmem_we === 1'b1)
            cells[i_dmem_waddr] <= i_dmem_wdata;
        if (i_cmem_re === 1'b1)
            o_code_rdata <= i_port2 ^ i_port0 ^ 8'h3c;
    end
endmodule // dmx_mem_model

// ### tb/tb.sv
// Self-checking bench for the data-move executor
`timescale 1ns/1ps
module tb;
    logic        i_clk;
    logic        i_nrst;
    logic        i_instr_valid;
    logic [7:0]  i_opcode;
    logic [7:0]  i_arg1;
    logic [7:0]  i_arg2;
    logic        o_instr_ready;
    logic        o_instr_done;
    logic        o_unknown;
    logic        o_dmem_re;
    logic [7:0]  o_dmem_raddr;
    logic [7:0]  i_dmem_rdata;
    logic        o_dmem_we;
    logic [7:0]  o_dmem_waddr;
    logic [7:0]  o_dmem_wdata;
    logic        o_cmem_re;
    logic [7:0]  o_port2;
    logic [7:0]  o_port0;
    logic [7:0]  i_code_rdata;
    logic [7:0]  o_acc;
    logic        o_carry;
    logic        o_parity;
    logic [15:0] o_data_pointer;
    logic [15:0] o_pc;
    logic [63:0] o_working_register;
    logic [15:0] cap;
    logic [15:0] pc_e;
    logic [7:0]  acc_e;
    int          fails;
    int          check_count;

    data_move_instruction_exec dut (.i_clk, .i_nrst, .i_instr_valid, .i_opcode, .i_arg1,
        .i_arg2, .o_instr_ready, .o_instr_done, .o_unknown, .o_dmem_re, .o_dmem_raddr,
        .i_dmem_rdata, .o_dmem_we, .o_dmem_waddr, .o_dmem_wdata, .o_cmem_re, .o_port2,
        .o_port0, .i_code_rdata, .o_acc, .o_carry, .o_parity, .o_data_pointer, .o_pc,
        .o_working_register);

    dmx_mem_model u_mem (.i_clk, .i_dmem_re(o_dmem_re), .i_dmem_raddr(o_dmem_raddr),
        .o_dmem_rdata(i_dmem_rdata), .i_dmem_we(o_dmem_we), .i_dmem_waddr(o_dmem_waddr),
        .i_dmem_wdata(o_dmem_wdata), .i_cmem_re(o_cmem_re), .i_port2(o_port2),
        .i_port0(o_port0), .o_code_rdata(i_code_rdata));

    initial
    begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    // Lookup address seen on the ports while the code strobe is up
    always @(posedge i_clk)
        if (o_cmem_re === 1'b1)
            cap <= {o_port2, o_port0};

    function automatic logic [7:0] cexp(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h3c;
    endfunction

    task automatic close_out;
        if (fails == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
        check_count++;
        if (got !== exp)
        begin
            fails++;
            $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task automatic run(input logic [7:0] op, input logic [7:0] a1, input logic [7:0] a2,
                       input int cyc, input int len, input logic unk);
        int   n;
        logic u;
        n = 0;
        @(posedge i_clk);
        i_instr_valid <= 1'b1;
        i_opcode      <= op;
        i_arg1        <= a1;
        i_arg2        <= a2;
        @(posedge i_clk);
        while (o_instr_ready !== 1'b1 && n < 20)
        begin
            n++;
            @(posedge i_clk);
        end
        if (n >= 20)
        begin
            fails++;
            close_out();
        end
        i_instr_valid <= 1'b0;
        n = 0;
        do
        begin
            @(posedge i_clk);
            n++;
        end
        while (o_instr_done !== 1'b1 && n < 9);
        u = o_unknown;
        if (n >= 9)
        begin
            fails++;
            close_out();
        end
        #1;
        pc_e = pc_e + 16'(len);
        chk(16'(n), 16'(cyc * dmx_pkg::CLKS_PER_CYC), "latency");
        chk(o_pc, pc_e, "pc");
        chk({15'h0000, u}, {15'h0000, unk}, "unknown flag");
    endtask

    task automatic t_pointer;
        logic [15:0] a;
        run(8'h90, 8'h12, 8'h34, 2, 3, 1'b0);
        chk(o_data_pointer, 16'h1234, "pointer load");
        a = 16'h1234 + {8'h00, acc_e};
        run(8'h93, 8'h00, 8'h00, 2, 1, 1'b0);
        acc_e = cexp(a);
        chk({8'h00, o_acc}, {8'h00, acc_e}, "pointer lookup");
        chk(o_data_pointer, 16'h1234, "pointer kept");
        chk(cap, a, "lookup ports");
        chk({15'h0000, o_parity}, {15'h0000, ^acc_e}, "parity");
    endtask

    task automatic t_regs;
        for (int r = 0; r < 8; r++)
        begin
            run(8'hf8 + 8'(r), 8'h00, 8'h00, 1, 1, 1'b0);
            chk({8'h00, o_working_register[8*r +: 8]}, {8'h00, acc_e}, "acc to reg");
        end
        for (int r = 0; r < 8; r++)
        begin
            run(8'h78 + 8'(r), 8'h10 + 8'(r), 8'h00, 1, 2, 1'b0);
            chk({8'h00, o_working_register[8*r +: 8]}, 16'h0010 + 16'(r), "imm reg");
        end
    endtask

    task automatic t_direct;
        run(8'hf5, 8'h45, 8'h00, 1, 2, 1'b0);
        chk({8'h00, u_mem.cells[8'h45]}, {8'h00, acc_e}, "acc to dir");
        run(8'h75, 8'h46, 8'h9c, 2, 3, 1'b0);
        chk({8'h00, u_mem.cells[8'h46]}, 16'h009c, "imm to dir");
        run(8'hab, 8'h46, 8'h00, 2, 2, 1'b0);
        chk({8'h00, o_working_register[31:24]}, 16'h009c, "dir to reg");
        run(8'h8d, 8'h47, 8'h00, 2, 2, 1'b0);
        chk({8'h00, u_mem.cells[8'h47]}, 16'h0015, "reg to dir");
        run(8'h85, 8'h46, 8'h48, 2, 3, 1'b0);
        chk({8'h00, u_mem.cells[8'h48]}, 16'h009c, "dir to dir");
        run(8'h86, 8'h49, 8'h00, 2, 2, 1'b0);
        chk({8'h00, u_mem.cells[8'h49]}, 16'h004a, "ind r0 to dir");
        run(8'h87, 8'h4a, 8'h00, 2, 2, 1'b0);
        chk({8'h00, u_mem.cells[8'h4a]}, 16'h004b, "ind r1 to dir");
    endtask

    task automatic t_bits;
        chk({15'h0000, o_carry}, 16'h0000, "carry untouched");
        run(8'ha2, 8'h06, 8'h00, 1, 2, 1'b0);
        chk({15'h0000, o_carry}, 16'h0001, "bit to carry low");
        run(8'h92, 8'h7f, 8'h00, 2, 2, 1'b0);
        chk({8'h00, u_mem.cells[8'h2f]}, 16'h00f5, "carry to bit low");
        run(8'ha2, 8'hb4, 8'h00, 1, 2, 1'b0);
        chk({15'h0000, o_carry}, 16'h0000, "bit to carry high");
        run(8'h92, 8'hb3, 8'h00, 2, 2, 1'b0);
        chk({8'h00, u_mem.cells[8'hb0]}, 16'h00e2, "carry to bit high");
    endtask

    task automatic t_pc_table;
        logic [15:0] a;
        a = pc_e + 16'h0001 + {8'h00, acc_e};
        run(8'h83, 8'h00, 8'h00, 2, 1, 1'b0);
        acc_e = cexp(a);
        chk({8'h00, o_acc}, {8'h00, acc_e}, "pc lookup");
        chk(cap, a, "pc lookup ports");
        chk({15'h0000, o_carry}, 16'h0000, "carry kept");
        chk({15'h0000, o_parity}, {15'h0000, ^acc_e}, "parity");
    endtask

    initial
    begin
        i_nrst        = 1'b0;
        i_instr_valid = 1'b0;
        i_opcode      = 8'h00;
        i_arg1        = 8'h00;
        i_arg2        = 8'h00;
        fails         = 0;
        check_count   = 0;
        pc_e          = 16'h0000;
        acc_e         = 8'h00;
        repeat (8) @(posedge i_clk);
        i_nrst <= 1'b1;
        @(posedge i_clk);
        #1;
        chk({15'h0000, o_instr_ready}, 16'h0001, "ready after reset");
        chk(o_pc, 16'h0000, "pc after reset");
        t_pointer();
        t_regs();
        t_direct();
        t_bits();
        t_pc_table();
        run(8'h00, 8'h00, 8'h00, 1, 1, 1'b1);
        close_out();
    end
endmodule // tb
